// ===== inc/lss_cfg_if.sv
`timescale 1ns/1ps
interface lss_cfg_if;
   lss_pkg::lss_mode_t mode;
   logic interlock;
   logic [8:0] interval_s;
   logic [8:0] duration_s;
   logic restart_cmd;
   logic shutdown;
   logic tx_on;
   logic probing;
   logic [lss_pkg::NUM_IRQ-1:0] events;
   modport regs (output mode, interlock, interval_s, duration_s, restart_cmd,
                 input shutdown, tx_on, probing, events);
   modport core (input mode, interlock, interval_s, duration_s, restart_cmd,
                 output shutdown, tx_on, probing, events);
endinterface : lss_cfg_if

// ===== inc/lss_pkg.sv
package lss_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned SEC_NS = 1000000000;
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
   localparam logic [8:0] INTERVAL_MIN_S = 9'd60;
   localparam logic [8:0] INTERVAL_MAX_S = 9'd300;
   localparam logic [8:0] INTERVAL_RST_S = 9'd100;
   localparam logic [8:0] DURATION_MIN_S = 9'd2;
   localparam logic [8:0] DURATION_MAX_S = 9'd100;
   localparam logic [8:0] DURATION_RST_S = 9'd2;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TIMING = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam logic [7:0] REG_RESTART = 8'h14;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_LOCK_BIT = 2;
   localparam int unsigned TIM_DUR_LSB = 16;
   localparam int unsigned STAT_SHUT_BIT = 0;
   localparam int unsigned STAT_MECH_BIT = 1;
   localparam int unsigned STAT_TXON_BIT = 2;
   localparam int unsigned STAT_LOS_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int unsigned NUM_IRQ = 3;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam int unsigned IRQ_SHUT = 0;
   localparam int unsigned IRQ_RESUME = 1;
   localparam int unsigned IRQ_PROBE = 2;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SAFETY_OFF = 2'h0,
      MODE_AUTO = 2'h1,
      MODE_MANUAL = 2'h2
   } lss_mode_t;
   localparam lss_mode_t MODE_RST = MODE_AUTO;
endpackage : lss_pkg

// ===== test/lss_link_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-end optics: receive loss follows the fiber state
// ----------------------------------------------------------------
module lss_link_model (
   input wire logic i_clk,      // System clock
   input wire logic i_sys_rst,  // Async reset, high
   input wire logic i_cut,      // Fiber broken
   output logic o_los           // Receive loss level
);
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) o_los <= 1'b0;
      else o_los <= i_cut;
   end
endmodule : lss_link_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, rst = 1'b1, cut = 1'b0, rxo = 1'b0, amp = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic los, tx, irq, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rr, br;
   int err_total = 0, n_tests = 0, cyc = 0, t0;
   always #20 clk = ~clk;
   // A short second keeps the 60 s interval at 1200 cycles
   lss_top #(.SEC_CYCLES(20)) i_lss_top (.i_clk(clk), .i_sys_rst(rst), .i_los(los),
      .i_rx_only(rxo), .i_amp_port(amp), .o_tx_enable(tx), .o_irq(irq), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
   lss_link_model i_lss_link_model (.i_clk(clk), .i_sys_rst(rst), .i_cut(cut), .o_los(los));
   // ----------------------------------------------------------------
   // Checks and bus tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic rng(input int v, input int lo, input int hi);
      n_tests++;
      if (v < lo || v > hi) begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h..%h", $time, v, lo, hi);
      end
   endtask : rng
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b, ta, tw, tb_;
      int k;
      @(posedge clk);
      aw = 1'b1;
      w = 1'b1;
      b = 1'b0;
      k = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b && k < 100) begin
         @(negedge clk);
         ta = aw && awready;
         tw = w && wready;
         tb_ = bvalid;
         if (tb_) br = bresp;
         k++;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb_) bready <= 1'b0;
         aw = aw && !ta;
         w = w && !tw;
         b = tb_;
      end
      chk(b, 1'b1);
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a);
      logic ar, r, ta;
      int k;
      @(posedge clk);
      ar = 1'b1;
      r = 1'b0;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r && k < 100) begin
         @(negedge clk);
         ta = ar && arready;
         r = rvalid;
         rd = rdata;
         rr = rresp;
         k++;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (r) rready <= 1'b0;
         ar = ar && !ta;
      end
      chk(r, 1'b1);
   endtask : bus_rd
   task automatic wtx(input logic v, input int lim);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (tx !== v && k < lim);
   endtask : wtx
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      bus_rd(lss_pkg::REG_CTRL);
      chk(rd, 32'h0000_0001);
      bus_rd(lss_pkg::REG_STATUS);
      chk(rd[2:0], 3'h4);
      bus_rd(8'h40);
      chk(rr, lss_pkg::RESP_SLVERR);
      bus_rd(lss_pkg::REG_RESTART);
      chk(rd, 32'h0);
      bus_wr(8'h40, 32'h0);
      chk(br, lss_pkg::RESP_SLVERR);
      $display("test reset done");
   endtask : t_reset
   task automatic t_auto;
      bus_wr(lss_pkg::REG_TIMING, 32'h0001_000a);
      chk(br, lss_pkg::RESP_OKAY);
      bus_rd(lss_pkg::REG_TIMING);
      chk(rd, 32'h0002_003c);
      bus_wr(lss_pkg::REG_IRQ_MASK, 32'h1);
      @(posedge clk) cut <= 1'b1;
      wtx(1'b0, 8);
      chk(tx, 1'b0);
      t0 = cyc;
      chk(irq, 1'b1);
      bus_rd(lss_pkg::REG_STATUS);
      chk(rd[0], 1'b1);
      bus_wr(lss_pkg::REG_RESTART, 32'h1);
      wtx(1'b1, 100);
      chk(tx, 1'b0);
      bus_rd(lss_pkg::REG_IRQ_STAT);
      chk(rd[0], 1'b1);
      @(negedge clk);
      chk(irq, 1'b0);
      wtx(1'b1, 1500);
      rng(cyc - t0, 1195, 1210);
      t0 = cyc;
      wtx(1'b0, 100);
      rng(cyc - t0, 20, 62);
      t0 = cyc;
      @(posedge clk) cut <= 1'b0;
      wtx(1'b1, 1500);
      rng(cyc - t0, 1180, 1222);
      wtx(1'b0, 100);
      chk(tx, 1'b1);
      $display("test auto done");
   endtask : t_auto
   task automatic t_manual;
      bus_wr(lss_pkg::REG_CTRL, 32'h2);
      @(posedge clk) cut <= 1'b1;
      wtx(1'b0, 8);
      wtx(1'b1, 1400);
      chk(tx, 1'b0);
      @(posedge clk) cut <= 1'b0;
      bus_wr(lss_pkg::REG_RESTART, 32'h1);
      wtx(1'b1, 8);
      chk(tx, 1'b1);
      wtx(1'b0, 80);
      chk(tx, 1'b1);
      bus_rd(lss_pkg::REG_STATUS);
      chk(rd[0], 1'b0);
      $display("test manual done");
   endtask : t_manual
   task automatic t_lock;
      bus_wr(lss_pkg::REG_CTRL, 32'h5);
      wtx(1'b0, 8);
      chk(tx, 1'b0);
      bus_rd(lss_pkg::REG_CTRL);
      chk(rd, 32'h5);
      bus_wr(lss_pkg::REG_CTRL, 32'h4);
      wtx(1'b1, 20);
      chk(tx, 1'b0);
      bus_wr(lss_pkg::REG_CTRL, 32'h0);
      @(posedge clk) cut <= 1'b1;
      wtx(1'b0, 30);
      chk(tx, 1'b1);
      @(posedge clk) rxo <= 1'b1;
      amp <= 1'b1;
      bus_wr(lss_pkg::REG_CTRL, 32'h1);
      wtx(1'b0, 30);
      chk(tx, 1'b1);
      bus_rd(lss_pkg::REG_STATUS);
      chk(rd[1], 1'b1);
      @(posedge clk) amp <= 1'b0;
      bus_rd(lss_pkg::REG_STATUS);
      chk(rd[1], 1'b0);
      $display("test interlock done");
   endtask : t_lock
   // Ceiling sits well above the roughly 4200 cycles the scenarios need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(tx, 1'b0);
      @(negedge clk);
      chk(tx, 1'b1);
      t_reset();
      t_auto();
      t_manual();
      t_lock();
      complete_run();
   end
endmodule : tb

// ===== verilog/lss_regs.sv
`timescale 1ns/1ps
module lss_regs (
   input wire logic i_clk,            // System clock
   input wire logic i_sys_rst,        // Async reset, high
   input wire logic i_rx_only,        // Receive-only port
   input wire logic i_amp_port,       // Amplifier port kind
   input wire logic i_los,            // Receive loss level
   input wire logic [7:0] i_awaddr,   // Write address
   input wire logic i_awvalid,        // Write address valid
   output logic o_awready,            // Write address ready
   input wire logic [31:0] i_wdata,   // Write data
   input wire logic [3:0] i_wstrb,    // Write strobes
   input wire logic i_wvalid,         // Write data valid
   output logic o_wready,             // Write data ready
   output logic [1:0] o_bresp,        // Write response
   output logic o_bvalid,             // Write response valid
   input wire logic i_bready,         // Write response ready
   input wire logic [7:0] i_araddr,   // Read address
   input wire logic i_arvalid,        // Read address valid
   output logic o_arready,            // Read address ready
   output logic [31:0] o_rdata,       // Read data
   output logic [1:0] o_rresp,        // Read response
   output logic o_rvalid,             // Read data valid
   input wire logic i_rready,         // Read data ready
   output logic o_irq,                // Interrupt level
   lss_cfg_if.regs cfg                // Core configuration
);
   logic aw_q, w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] mode_q;
   logic lock_q;
   logic [8:0] intv_q, dur_q;
   logic restart_q;
   logic [lss_pkg::NUM_IRQ-1:0] irq_stat_q, irq_mask_q;
   logic wr_go, rd_go, stat_rd;
   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   assign o_awready = !aw_q && !o_bvalid;
   assign o_wready = !w_q && !o_bvalid;
   assign wr_go = aw_q && w_q && !o_bvalid;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= i_awaddr;
         end else if (wr_go) begin
            aw_q <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
         end else if (wr_go) begin
            w_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= lss_pkg::RESP_OKAY;
      end else if (wr_go) begin
         o_bvalid <= 1'b1;
         if (awaddr_q == lss_pkg::REG_CTRL || awaddr_q == lss_pkg::REG_TIMING ||
             awaddr_q == lss_pkg::REG_IRQ_MASK || awaddr_q == lss_pkg::REG_RESTART) begin
            o_bresp <= lss_pkg::RESP_OKAY;
         end else begin
            o_bresp <= lss_pkg::RESP_SLVERR;
         end
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_q <= lss_pkg::MODE_RST;
         lock_q <= 1'b0;
         intv_q <= lss_pkg::INTERVAL_RST_S;
         dur_q <= lss_pkg::DURATION_RST_S;
         irq_mask_q <= lss_pkg::IRQ_RST;
         restart_q <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         if (wr_go && awaddr_q == lss_pkg::REG_CTRL && wstrb_q[0]) begin
            // Code 3 is not a mode; keep the old one
            if (wdata_q[lss_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
               mode_q <= wdata_q[lss_pkg::CTRL_MODE_LSB +: 2];
            end
            lock_q <= wdata_q[lss_pkg::CTRL_LOCK_BIT];
         end else if (wr_go && awaddr_q == lss_pkg::REG_TIMING) begin
            // Out-of-range values are clamped so the probe never runs wild
            if (wstrb_q[1:0] == 2'h3) begin
               if (wdata_q[8:0] < lss_pkg::INTERVAL_MIN_S) intv_q <= lss_pkg::INTERVAL_MIN_S;
               else if (wdata_q[8:0] > lss_pkg::INTERVAL_MAX_S) intv_q <= lss_pkg::INTERVAL_MAX_S;
               else intv_q <= wdata_q[8:0];
            end
            if (wstrb_q[3:2] == 2'h3) begin
               if (wdata_q[24:16] < lss_pkg::DURATION_MIN_S) dur_q <= lss_pkg::DURATION_MIN_S;
               else if (wdata_q[24:16] > lss_pkg::DURATION_MAX_S) dur_q <= lss_pkg::DURATION_MAX_S;
               else dur_q <= wdata_q[lss_pkg::TIM_DUR_LSB +: 9];
            end
         end else if (wr_go && awaddr_q == lss_pkg::REG_IRQ_MASK && wstrb_q[0]) begin
            irq_mask_q <= wdata_q[lss_pkg::NUM_IRQ-1:0];
         end else if (wr_go && awaddr_q == lss_pkg::REG_RESTART && wstrb_q[0]) begin
            restart_q <= wdata_q[0];
         end
      end
   end
   // Receive-only ports see safety_off whatever was written
   assign cfg.mode = i_rx_only ? lss_pkg::MODE_SAFETY_OFF : lss_pkg::lss_mode_t'(mode_q);
   assign cfg.interlock = lock_q;
   assign cfg.interval_s = intv_q;
   assign cfg.duration_s = dur_q;
   assign cfg.restart_cmd = restart_q;
   // ----------------------------------------------------------------
   // Read channel and interrupts
   // ----------------------------------------------------------------
   assign o_arready = !o_rvalid;
   assign rd_go = i_arvalid && o_arready;
   assign stat_rd = rd_go && i_araddr == lss_pkg::REG_IRQ_STAT;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= lss_pkg::RESP_OKAY;
      end else if (rd_go) begin
         o_rvalid <= 1'b1;
         o_rresp <= lss_pkg::RESP_OKAY;
         o_rdata <= 32'h0;
         if (i_araddr == lss_pkg::REG_CTRL) begin
            o_rdata <= {29'h0, lock_q, mode_q};
         end else if (i_araddr == lss_pkg::REG_TIMING) begin
            o_rdata <= {7'h0, dur_q, 7'h0, intv_q};
         end else if (i_araddr == lss_pkg::REG_STATUS) begin
            o_rdata <= {28'h0, i_los, cfg.tx_on, i_amp_port, cfg.shutdown};
         end else if (i_araddr == lss_pkg::REG_IRQ_STAT) begin
            o_rdata <= {29'h0, irq_stat_q};
         end else if (i_araddr == lss_pkg::REG_IRQ_MASK) begin
            o_rdata <= {29'h0, irq_mask_q};
         end else if (i_araddr != lss_pkg::REG_RESTART) begin
            o_rresp <= lss_pkg::RESP_SLVERR;
         end
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
   // New events win over the read-clear
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_stat_q <= lss_pkg::IRQ_RST;
      end else begin
         irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | cfg.events;
      end
   end
   assign o_irq = |(irq_stat_q & irq_mask_q);
endmodule : lss_regs

// ===== verilog/lss_tick.sv
`timescale 1ns/1ps
module lss_tick #(
   parameter int unsigned SEC_CYCLES = lss_pkg::SEC_CYCLES
) (
   input wire logic i_clk,      // System clock
   input wire logic i_sys_rst,  // Async reset, high
   input wire logic i_clr,      // Restart the second
   output logic o_tick          // One-second pulse
);
   logic [24:0] cnt_q;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= 25'h0;
      end else if (i_clr || cnt_q == 25'(SEC_CYCLES - 1)) begin
         cnt_q <= 25'h0;
      end else begin
         cnt_q <= cnt_q + 25'h1;
      end
   end
   assign o_tick = !i_clr && cnt_q == 25'(SEC_CYCLES - 1);
endmodule : lss_tick

// ===== verilog/lss_top.sv
`timescale 1ns/1ps
module lss_top #(
   parameter int unsigned SEC_CYCLES = lss_pkg::SEC_CYCLES
) (
   input wire logic i_clk,            // System clock, 25 MHz
   input wire logic i_sys_rst,        // Async reset, high
   input wire logic i_los,            // Receive optical signal lost
   input wire logic i_rx_only,        // Port only receives
   input wire logic i_amp_port,       // Port is an amplifier
   output logic o_tx_enable,          // Transmit laser on
   output logic o_irq,                // Interrupt level
   input wire logic [7:0] i_awaddr,   // Write address
   input wire logic i_awvalid,        // Write address valid
   output logic o_awready,            // Write address ready
   input wire logic [31:0] i_wdata,   // Write data
   input wire logic [3:0] i_wstrb,    // Write strobes
   input wire logic i_wvalid,         // Write data valid
   output logic o_wready,             // Write data ready
   output logic [1:0] o_bresp,        // Write response
   output logic o_bvalid,             // Write response valid
   input wire logic i_bready,         // Write response ready
   input wire logic [7:0] i_araddr,   // Read address
   input wire logic i_arvalid,        // Read address valid
   output logic o_arready,            // Read address ready
   output logic [31:0] o_rdata,       // Read data
   output logic [1:0] o_rresp,        // Read response
   output logic o_rvalid,             // Read data valid
   input wire logic i_rready          // Read data ready
);
   typedef enum logic [1:0] {
      ST_WORK,
      ST_SHUT,
      ST_PROBE
   } lss_state_t;

   lss_cfg_if cfg ();
   lss_state_t state_q;
   logic [8:0] sec_q;
   logic tick, tick_clr;
   logic safety_on, forced_off, restart_seen_q;
   logic [lss_pkg::NUM_IRQ-1:0] ev;

   lss_regs u_regs (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_rx_only(i_rx_only),
      .i_amp_port(i_amp_port),
      .i_los(i_los),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_irq(o_irq),
      .cfg(cfg.regs)
   );

   lss_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clr(tick_clr),
      .o_tick(tick)
   );

   // ----------------------------------------------------------------
   // Shutdown state machine
   // ----------------------------------------------------------------
   assign safety_on = cfg.mode != lss_pkg::MODE_SAFETY_OFF;
   // Second counter held while working or awaiting a manual restart,
   // so every probe pulse starts on a whole second
   assign tick_clr = state_q == ST_WORK
                     || (state_q == ST_SHUT && cfg.mode == lss_pkg::MODE_MANUAL);

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ST_WORK;
         sec_q <= 9'h0;
      end else begin
         case (state_q)
            ST_WORK: begin
               sec_q <= 9'h0;
               if (safety_on && i_los) begin
                  state_q <= ST_SHUT;
               end
            end
            ST_SHUT: begin
               if (!safety_on) begin
                  state_q <= ST_WORK;
               end else if (cfg.mode == lss_pkg::MODE_MANUAL) begin
                  sec_q <= 9'h0;
                  if (cfg.restart_cmd) begin
                     state_q <= ST_PROBE;
                  end
               end else if (tick) begin
                  if (sec_q + 9'h1 >= cfg.interval_s) begin
                     sec_q <= 9'h0;
                     state_q <= ST_PROBE;
                  end else begin
                     sec_q <= sec_q + 9'h1;
                  end
               end
            end
            ST_PROBE: begin
               if (!safety_on) begin
                  state_q <= ST_WORK;
               end else if (tick) begin
                  if (sec_q + 9'h1 >= cfg.duration_s) begin
                     sec_q <= 9'h0;
                     // Failure cleared during the pulse: resume
                     state_q <= i_los ? ST_SHUT : ST_WORK;
                  end else begin
                     sec_q <= sec_q + 9'h1;
                  end
               end
            end
            default: begin
               state_q <= ST_WORK;
            end
         endcase
      end
   end

   // Restart command only counts in manual mode; the core drops it otherwise
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         restart_seen_q <= 1'b0;
      end else begin
         restart_seen_q <= cfg.restart_cmd && cfg.mode == lss_pkg::MODE_MANUAL
                           && state_q == ST_SHUT;
      end
   end

   // Interlock overrides everything, even with safety off
   assign forced_off = cfg.interlock;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tx_enable <= 1'b0;
      end else begin
         o_tx_enable <= !forced_off && state_q != ST_SHUT;
      end
   end

   assign cfg.shutdown = state_q != ST_WORK;
   assign cfg.tx_on = o_tx_enable;
   assign cfg.probing = state_q == ST_PROBE;
   assign ev[lss_pkg::IRQ_SHUT] = state_q == ST_WORK && safety_on && i_los;
   assign ev[lss_pkg::IRQ_RESUME] = state_q == ST_PROBE && safety_on && tick && !i_los
                                    && sec_q + 9'h1 >= cfg.duration_s;
   assign ev[lss_pkg::IRQ_PROBE] = state_q == ST_SHUT && safety_on
                                   && ((cfg.mode == lss_pkg::MODE_MANUAL && cfg.restart_cmd)
                                   || (cfg.mode == lss_pkg::MODE_AUTO && tick
                                   && sec_q + 9'h1 >= cfg.interval_s));
   assign cfg.events = ev;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_shut_on_los;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_WORK && safety_on && i_los |=> state_q == ST_SHUT;
   endproperty
   a_shut_on_los: assert property (p_shut_on_los) else $error("no shutdown on loss");

   property p_tx_off_shut;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_SHUT |=> !o_tx_enable;
   endproperty
   a_tx_off_shut: assert property (p_tx_off_shut) else $error("laser on in shutdown");

   property p_lock_off;
      @(posedge i_clk) disable iff (i_sys_rst)
      cfg.interlock |=> !o_tx_enable;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("interlock ignored");

   property p_rx_only;
      @(posedge i_clk) disable iff (i_sys_rst)
      i_rx_only |-> cfg.mode == lss_pkg::MODE_SAFETY_OFF;
   endproperty
   a_rx_only: assert property (p_rx_only) else $error("rx-only port active");

   property p_manual_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_SHUT && cfg.mode == lss_pkg::MODE_MANUAL && !cfg.restart_cmd
      |=> state_q == ST_SHUT;
   endproperty
   a_manual_hold: assert property (p_manual_hold) else $error("manual left shut");

   property p_cmd_ignored;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_SHUT && cfg.mode == lss_pkg::MODE_AUTO && !tick |=> state_q == ST_SHUT;
   endproperty
   a_cmd_ignored: assert property (p_cmd_ignored) else $error("restart in auto");

   property p_interval_range;
      @(posedge i_clk) disable iff (i_sys_rst)
      cfg.interval_s >= lss_pkg::INTERVAL_MIN_S && cfg.interval_s <= lss_pkg::INTERVAL_MAX_S;
   endproperty
   a_interval_range: assert property (p_interval_range) else $error("interval range");

   property p_duration_range;
      @(posedge i_clk) disable iff (i_sys_rst)
      cfg.duration_s >= lss_pkg::DURATION_MIN_S && cfg.duration_s <= lss_pkg::DURATION_MAX_S;
   endproperty
   a_duration_range: assert property (p_duration_range) else $error("duration range");

   property p_probe_end;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_PROBE && safety_on && tick && sec_q + 9'h1 >= cfg.duration_s && !i_los
      |=> state_q == ST_WORK ##1 o_tx_enable || cfg.interlock;
   endproperty
   a_probe_end: assert property (p_probe_end) else $error("no resume");

   property p_probe_fail;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_PROBE && safety_on && tick && sec_q + 9'h1 >= cfg.duration_s && i_los
      |=> state_q == ST_SHUT;
   endproperty
   a_probe_fail: assert property (p_probe_fail) else $error("no shutdown after probe");

   property p_probe_tx;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_PROBE && !cfg.interlock |=> o_tx_enable;
   endproperty
   a_probe_tx: assert property (p_probe_tx) else $error("laser off in probe");

   property p_manual_probe;
      @(posedge i_clk) disable iff (i_sys_rst)
      state_q == ST_SHUT && cfg.mode == lss_pkg::MODE_MANUAL && cfg.restart_cmd
      |=> state_q == ST_PROBE;
   endproperty
   a_manual_probe: assert property (p_manual_probe) else $error("manual probe missed");

   property p_safety_off_work;
      @(posedge i_clk) disable iff (i_sys_rst)
      !safety_on && state_q != ST_WORK |=> state_q == ST_WORK;
   endproperty
   a_safety_off_work: assert property (p_safety_off_work) else $error("safety off held");


   c_shut: cover property (@(posedge i_clk) state_q == ST_WORK ##1 state_q == ST_SHUT);
   c_probe: cover property (@(posedge i_clk) state_q == ST_SHUT ##1 state_q == ST_PROBE);
   c_resume: cover property (@(posedge i_clk) state_q == ST_PROBE ##1 state_q == ST_WORK);
   c_manual: cover property (@(posedge i_clk) restart_seen_q);
endmodule : lss_top
